//--- verilog/memsel_defines.svh
// Summary of operation
// - low select top from 3-bit field: 000 64K to 111 512K ending 7FFFFh
// - low select drives address in address phase unless its disable bit is set
// - upper select omits address in address phase when its disable bit is set
// - strap low at reset release forces address drive, ignoring disable bits
// - pseudo-static support on low select only when bit 6 is set
// - ready bit 0 waits for external ready, 1 ignores it; wait states always
// - low select inserts 0 to 3 wait states from two-bit field
// - upper select resets active over F0000h-FFFFFh, ready needed, 3 waits
// - upper block always ends at FFFFFh; only its bottom is programmable
// - upper block bottom from field: 111 F0000h, 110 E0000h, 100 C0000h, 000 80000h
// - low select inactive after reset, activated by any write to its register
// - low register resets in full to 0000h, disable bit included
`ifndef MEMSEL_DEFINES_SVH
`define MEMSEL_DEFINES_SVH
`define UPPER_SEL_OFS      8'hA0
`define LOW_SEL_OFS        8'hA2
`define REFRESH_EN_OFS     8'hE4
`define UPPER_SEL_RESET    16'hF03B
`define LOW_SEL_RESET      16'h0000
`define BOUND_MSB          14
`define BOUND_LSB          12
`define ADDR_DIS_BIT       7
`define PSEUDO_EN_BIT      6
`define READY_MODE_BIT     2
`define WAIT_MSB           1
`define WAIT_LSB           0
`define REFRESH_EN_BIT     15
`endif

//--- verilog/memsel_pkg.sv
package memsel_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WAIT = 3'h2,
      ST_RDY  = 3'h4
   } cycle_e;
   typedef logic [15:0] reg_t;
endpackage

//--- verilog/select_timer.sv
`timescale 1ns/1ps
`include "memsel_defines.svh"
module select_timer (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [1:0] waits,
   input  wire logic       ignore_ready,
   input  wire logic       ext_ready,
   output logic            busy,
   output logic            done
);
   memsel_pkg::cycle_e state_q;
   memsel_pkg::cycle_e state_d;
   logic [1:0]         cnt_q;
   logic [1:0]         cnt_d;
   logic               done_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      done_d  = 1'b0;
      unique case (state_q)
         memsel_pkg::ST_IDLE: begin
            if (start) begin
               cnt_d   = waits;
               state_d = memsel_pkg::ST_WAIT;
            end
         end
         memsel_pkg::ST_WAIT: begin
            if (cnt_q != 2'h0) begin
               cnt_d = cnt_q - 2'h1;
            end else begin
               state_d = memsel_pkg::ST_RDY;
            end
         end
         memsel_pkg::ST_RDY: begin
            if (ignore_ready || ext_ready) begin
               done_d  = 1'b1;
               state_d = memsel_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = memsel_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= memsel_pkg::ST_IDLE;
         cnt_q   <= 2'h0;
         done    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         done    <= done_d;
      end
   end

   assign busy = (state_q != memsel_pkg::ST_IDLE);
endmodule

//--- verilog/memory_select.sv
`timescale 1ns/1ps
`include "memsel_defines.svh"
module memory_select (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        addr_en_strap_n,
   input  wire logic        cycle_start,
   input  wire logic        cycle_is_mem,
   input  wire logic [19:0] cycle_addr,
   input  wire logic        ext_ready,
   output logic             low_sel_n,
   output logic             upper_sel_n,
   output logic             addr_drive,
   output logic             cycle_done,
   output logic             pseudo_static_mode,
   output logic             midrange3_refresh_pin_n,
   input  wire logic        midrange3_sel_n,
   input  wire logic        refresh_req_n
);
   memsel_pkg::reg_t upper_memory_select_config_q;
   memsel_pkg::reg_t low_memory_select_config_q;
   memsel_pkg::reg_t refresh_enable_reg_q;
   logic             low_active_q;
   logic             force_addr_q;
   logic             rst_seen_q;

   function automatic logic [19:0] low_top(input logic [2:0] f);
      low_top = {1'b0, f, 16'hFFFF};
   endfunction

   function automatic logic [19:0] upper_bottom(input logic [2:0] f);
      upper_bottom = {1'b1, f, 16'h0000};
   endfunction

   wire wr_upper = reg_wr && (reg_addr == `UPPER_SEL_OFS);
   wire wr_low   = reg_wr && (reg_addr == `LOW_SEL_OFS);
   wire wr_rfsh  = reg_wr && (reg_addr == `REFRESH_EN_OFS);

   wire [2:0] low_top_field =
      low_memory_select_config_q[`BOUND_MSB:`BOUND_LSB];
   wire [2:0] upper_bottom_field =
      upper_memory_select_config_q[`BOUND_MSB:`BOUND_LSB];

   wire low_in_range   = cycle_addr <= low_top(low_top_field);
   wire upper_in_range = cycle_addr >= upper_bottom(upper_bottom_field);
   wire low_hit   = cycle_start && cycle_is_mem && low_active_q && low_in_range;
   wire upper_hit = cycle_start && cycle_is_mem && upper_in_range && !low_hit;
   wire any_hit   = low_hit || upper_hit;

   wire low_dis   = low_memory_select_config_q[`ADDR_DIS_BIT];
   wire upper_dis = upper_memory_select_config_q[`ADDR_DIS_BIT];
   wire addr_drive_d = force_addr_q ? 1'b1 :
                       low_hit ? !low_dis :
                       upper_hit ? !upper_dis : 1'b1;

   wire [1:0] waits_sel = low_hit ?
      low_memory_select_config_q[`WAIT_MSB:`WAIT_LSB] :
      upper_memory_select_config_q[`WAIT_MSB:`WAIT_LSB];
   wire ign_sel = low_hit ?
      low_memory_select_config_q[`READY_MODE_BIT] :
      upper_memory_select_config_q[`READY_MODE_BIT];

   logic [1:0] waits_q;
   logic       ign_q;
   logic       timer_busy;
   logic       timer_done;
   logic       start_q;

   select_timer u_timer (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .start        (start_q),
      .waits        (waits_q),
      .ignore_ready (ign_q),
      .ext_ready    (ext_ready),
      .busy         (timer_busy),
      .done         (timer_done)
   );

   wire refresh_on = refresh_enable_reg_q[`REFRESH_EN_BIT];
   wire pin_d      = refresh_on ? refresh_req_n : midrange3_sel_n;
   wire accept     = any_hit && !timer_busy && !start_q;

   wire [15:0] rdata_d =
      (reg_addr == `UPPER_SEL_OFS)  ? upper_memory_select_config_q :
      (reg_addr == `LOW_SEL_OFS)    ? low_memory_select_config_q :
      (reg_addr == `REFRESH_EN_OFS) ? refresh_enable_reg_q : 16'h0000;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         upper_memory_select_config_q <= `UPPER_SEL_RESET;
         low_memory_select_config_q   <= `LOW_SEL_RESET;
         refresh_enable_reg_q         <= 16'h0000;
         low_active_q                 <= 1'b0;
      end else begin
         if (wr_upper) begin
            upper_memory_select_config_q <= reg_wdata;
         end
         if (wr_low) begin
            low_memory_select_config_q <= reg_wdata;
            low_active_q               <= 1'b1;
         end
         if (wr_rfsh) begin
            refresh_enable_reg_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rst_seen_q      <= 1'b0;
         force_addr_q    <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
         if (!rst_seen_q) begin
            force_addr_q <= !addr_en_strap_n;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         start_q     <= 1'b0;
         waits_q     <= 2'h0;
         ign_q       <= 1'b0;
      end else begin
         start_q <= accept;
         if (accept) begin
            waits_q     <= waits_sel;
            ign_q       <= ign_sel;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata               <= 16'h0000;
         low_sel_n               <= 1'b1;
         upper_sel_n             <= 1'b1;
         addr_drive              <= 1'b1;
         cycle_done              <= 1'b0;
         pseudo_static_mode      <= 1'b0;
         midrange3_refresh_pin_n <= 1'b1;
      end else begin
         reg_rdata <= reg_rd ? rdata_d : 16'h0000;
         if (accept) begin
            low_sel_n   <= !low_hit;
            upper_sel_n <= !upper_hit;
            addr_drive  <= addr_drive_d;
         end else if (timer_done) begin
            low_sel_n   <= 1'b1;
            upper_sel_n <= 1'b1;
            addr_drive  <= 1'b1;
         end
         cycle_done <= timer_done;
         pseudo_static_mode <= low_active_q &&
                               low_memory_select_config_q[`PSEUDO_EN_BIT];
         midrange3_refresh_pin_n <= pin_d;
      end
   end
endmodule

//--- sim/memsel_asserts.sv
`timescale 1ns/1ps
module memsel_asserts (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        cycle_start,
   input wire logic        cycle_is_mem,
   input wire logic [19:0] cycle_addr,
   input wire logic        low_sel_n,
   input wire logic        upper_sel_n,
   input wire logic        addr_drive,
   input wire logic        cycle_done
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_one_select: assert property (low_sel_n || upper_sel_n)
      else $error("both selects low");
   a_low_cause: assert property ($fell(low_sel_n) |->
      $past(cycle_start && cycle_is_mem && cycle_addr < 20'h80000)) else $error("low select");
   a_upper_cause: assert property ($fell(upper_sel_n) |->
      $past(cycle_start && cycle_is_mem)) else $error("upper select");
   a_done_early: assert property ($fell(low_sel_n && upper_sel_n) |-> !cycle_done [*4])
      else $error("done early");
   a_done_late: assert property ($fell(low_sel_n && upper_sel_n) |-> ##[4:40] cycle_done)
      else $error("done late");
   a_done_release: assert property (cycle_done |-> low_sel_n && upper_sel_n)
      else $error("select held");
   a_done_pulse: assert property (cycle_done |=> !cycle_done)
      else $error("done length");
   a_addr_idle: assert property (low_sel_n && upper_sel_n |-> addr_drive)
      else $error("address off");
endmodule
bind memory_select memsel_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .cycle_start(cycle_start),
   .cycle_is_mem(cycle_is_mem), .cycle_addr(cycle_addr), .low_sel_n(low_sel_n),
   .upper_sel_n(upper_sel_n), .addr_drive(addr_drive), .cycle_done(cycle_done));

//--- sim/mem_partner.sv
`timescale 1ns/1ps
module mem_partner (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       sel_n,
   input  wire logic [3:0] lag,
   output logic            ext_ready
);
   logic [3:0] cnt_q;
   logic       tog_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         tog_q <= 1'b0;
      end else begin
         tog_q <= ~tog_q;
         cnt_q <= sel_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
      end
   end
   // ready after lag selected cycles, a changing level while deselected
   assign ext_ready = sel_n ? tog_q : (cnt_q >= lag);
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        sys_clk, ext_ready, low_sel_n, upper_sel_n, addr_drive, cycle_done, ps, pin_n;
   logic        rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, strap_n = 1'b1, start = 1'b0, mem = 1'b1;
   logic        mid_n = 1'b1, rf_n = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wd = 16'h0000, rdata;
   logic [19:0] ca = 20'h00000;
   logic [3:0]  lag = 4'h0;
   int          err_total = 0, checked = 0, base, k;
   memory_select u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
      .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .addr_en_strap_n(strap_n),
      .cycle_start(start), .cycle_is_mem(mem), .cycle_addr(ca), .ext_ready(ext_ready),
      .low_sel_n(low_sel_n), .upper_sel_n(upper_sel_n), .addr_drive(addr_drive),
      .cycle_done(cycle_done), .pseudo_static_mode(ps), .midrange3_refresh_pin_n(pin_n),
      .midrange3_sel_n(mid_n), .refresh_req_n(rf_n));
   mem_partner u_mem (.sys_clk(sys_clk), .rst(rst), .sel_n(low_sel_n & upper_sel_n),
      .lag(lag), .ext_ready(ext_ready));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task rst_dut;
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      wr_s <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge sys_clk);
      wr_s <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1;
      chk(32'(rdata), 32'(e));
   endtask
   task acc(input logic [19:0] a, input logic m, input logic [3:0] e);
      start <= 1'b1;
      ca <= a;
      mem <= m;
      @(posedge sys_clk);
      start <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(32'({low_sel_n, upper_sel_n, addr_drive, ps}), 32'(e));
      k = 0;
      while (cycle_done !== 1'b1 && k < 40) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      if (e[3:2] == 2'b11) chk(k, 40);
      else if (k == 40) begin
         chk(32'(cycle_done), 32'h1);
         stop_test();
      end
   endtask
   task t_reset;
      rd(8'hA0, 16'hF03B);
      rd(8'hA2, 16'h0000);
      rd(8'h10, 16'h0000);
      acc(20'h00000, 1'b1, 4'hE);
      acc(20'hFFFF0, 1'b0, 4'hE);
   endtask
   task t_low;
      lag = 4'hF;
      for (int w = 0; w < 4; w++) begin
         wr(8'hA2, {1'b0, 3'((1 << w) - 1), 6'h3E, 4'hF, 2'(w)});
         acc(20'((20'h10000 << w) - 1), 1'b1, 4'h4);
         if (w == 0) base = k;
         chk(k, base + w);
         acc(20'(20'h10000 << w), 1'b1, 4'hE);
      end
      wr(8'hE4, 16'h8000);
      wr(8'hA2, 16'h0F7C);
      acc(20'h00100, 1'b1, 4'h7);
   endtask
   task t_upper;
      lag = 4'h0;
      wr(8'hA2, 16'h0F3C);
      acc(20'hF0000, 1'b1, 4'hA);
      chk(k, base + 3);
      for (int w = 0; w < 4; w++) begin
         wr(8'hA0, {1'b1, ~3'((1 << w) - 1), 6'h02, 4'hE, 2'h0});
         acc(~20'((20'h10000 << w) - 1), 1'b1, 4'h8);
         chk(k, base);
         if (w < 3) acc(~20'((20'h10000 << w) - 1) - 20'h1, 1'b1, 4'hE);
      end
      rd(8'hA0, 16'h80B8);
      lag = 4'h8;
      acc(20'hFFFFF, 1'b1, 4'h8);
      chk(k, base + 6);
   endtask
   task t_pins;
      rf_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(32'(pin_n), 32'h0);
      rf_n <= 1'b1;
      mid_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(32'(pin_n), 32'h1);
      wr(8'hE4, 16'h0000);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(32'(pin_n), 32'h0);
      mid_n <= 1'b1;
      strap_n <= 1'b0;
      rst_dut();
      acc(20'h00010, 1'b1, 4'hE);
      wr(8'hA2, 16'h0FBC);
      acc(20'h00010, 1'b1, 4'h6);
   endtask
   initial begin
      rst_dut();
      t_reset();
      t_low();
      t_upper();
      t_pins();
      stop_test();
   end
endmodule
